// ---- hdl/dpmbx_consts.svh ----
// register offsets, field positions and reset values of the mailbox block
`ifndef DPMBX_CONSTS_SVH
`define DPMBX_CONSTS_SVH

// ****************************************************************
// register offsets, byte addresses on each side's register port
// ****************************************************************
`define DPMBX_OFS_OUT_MB    6'h00
`define DPMBX_OFS_IN_MB     6'h10
`define DPMBX_OFS_FLAGS     6'h20
`define DPMBX_OFS_IRQ_CTRL  6'h24
`define DPMBX_OFS_GEN_CTRL  6'h28

// ****************************************************************
// field positions
// ****************************************************************
`define DPMBX_BIT_LOW_EN    4
`define DPMBX_BIT_HIGH_EN   12
`define DPMBX_BIT_REQ_A     16
`define DPMBX_BIT_REQ_B     17
`define DPMBX_BIT_FLAG_RST  27
`define DPMBX_HALF_WIDTH    16

// ****************************************************************
// reset values
// ****************************************************************
`define DPMBX_RST_CFG       5'h00
`define DPMBX_RST_FLAGS     16'h0000
`define DPMBX_RST_BYTE      8'h00
`define DPMBX_RST_WORD      32'h00000000

`endif

// ---- hdl/dpmbx_pkg.sv ----
// types shared by the mailbox block files
`default_nettype none

package dpmbx_pkg;
  typedef logic [5:0]  dpmbx_addr_t;
  typedef logic [31:0] dpmbx_word_t;
  typedef logic [15:0] dpmbx_flags_t;
  typedef logic [4:0]  dpmbx_cfg_t;
  typedef logic [3:0]  dpmbx_be_t;

  // register region hit by an access
  typedef enum logic [5:0] {
    DPMBX_REG_NONE  = 6'b000001,
    DPMBX_REG_OUTB  = 6'b000010,
    DPMBX_REG_INB   = 6'b000100,
    DPMBX_REG_FLAGS = 6'b001000,
    DPMBX_REG_IRQ   = 6'b010000,
    DPMBX_REG_GEN   = 6'b100000
  } dpmbx_region_t;
endpackage : dpmbx_pkg

`default_nettype wire

// ---- hdl/dpmbx_port.sv ----
// register port decode and read-back of one side of the mailbox block
`default_nettype none
`include "dpmbx_consts.svh"

module dpmbx_port
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // register access
  input  wire logic                 cs,
  input  wire logic                 we,
  input  wire dpmbx_pkg::dpmbx_addr_t addr,
  input  wire dpmbx_pkg::dpmbx_be_t   be,
  output var  dpmbx_pkg::dpmbx_word_t rdata,
  output var  logic                 ack,
  // state to read back
  input  wire logic [127:0]         out_words,
  input  wire logic [127:0]         in_words,
  input  wire dpmbx_pkg::dpmbx_word_t flags,
  input  wire dpmbx_pkg::dpmbx_word_t irq_word,
  // access pulses to the core
  output var  dpmbx_pkg::dpmbx_flags_t out_wr,
  output var  dpmbx_pkg::dpmbx_flags_t in_rd,
  output var  logic                 irq_wr,
  output var  logic                 gen_wr
);
  import dpmbx_pkg::*;

  dpmbx_region_t region;
  dpmbx_word_t   next_rdata;
  logic [3:0]    lane_shift;

  // ****************************************************************
  // address decode
  // ****************************************************************
  always_comb
  begin
    region = DPMBX_REG_NONE;
    if (addr[5:4] == 2'(`DPMBX_OFS_OUT_MB >> 4))
      region = DPMBX_REG_OUTB;
    else if (addr[5:4] == 2'(`DPMBX_OFS_IN_MB >> 4))
      region = DPMBX_REG_INB;
    else if (addr == `DPMBX_OFS_FLAGS)
      region = DPMBX_REG_FLAGS;
    else if (addr == `DPMBX_OFS_IRQ_CTRL)
      region = DPMBX_REG_IRQ;
    else if (addr == `DPMBX_OFS_GEN_CTRL)
      region = DPMBX_REG_GEN;
  end

  assign lane_shift = {addr[3:2], 2'b00};

  // byte strobes: index is mailbox times four plus byte
  always_comb
  begin
    out_wr = '0;
    in_rd  = '0;
    irq_wr = 1'b0;
    gen_wr = 1'b0;
    if (cs && we && region == DPMBX_REG_OUTB)
      out_wr = {12'h000, be} << lane_shift;
    if (cs && !we && region == DPMBX_REG_INB)
      in_rd = {12'h000, be} << lane_shift;
    // flag and incoming regions take no write
    if (cs && we && region == DPMBX_REG_IRQ)
      irq_wr = 1'b1;
    if (cs && we && region == DPMBX_REG_GEN)
      gen_wr = 1'b1;
  end

  // ****************************************************************
  // read-back, unmapped and write-only reads give zero
  // ****************************************************************
  always_comb
  begin
    case (region)
      DPMBX_REG_OUTB:  next_rdata = out_words[{addr[3:2], 5'b00000} +: 32];
      DPMBX_REG_INB:   next_rdata = in_words[{addr[3:2], 5'b00000} +: 32];
      DPMBX_REG_FLAGS: next_rdata = flags;
      DPMBX_REG_IRQ:   next_rdata = irq_word;
      default:         next_rdata = `DPMBX_RST_WORD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= `DPMBX_RST_WORD;
      ack   <= 1'b0;
    end
    else
    begin
      ack <= cs;
      if (cs && !we)
        rdata <= next_rdata;
    end
  end
endmodule : dpmbx_port

`default_nettype wire

// ---- hdl/dpmbx_top.sv ----
// dual-port mailbox core with status flags and mailbox interrupts
`default_nettype none
`include "dpmbx_consts.svh"

module dpmbx_top
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // pci side register port
  input  wire logic                   pci_cs,
  input  wire logic                   pci_we,
  input  wire dpmbx_pkg::dpmbx_addr_t pci_addr,
  input  wire dpmbx_pkg::dpmbx_be_t   pci_be,
  input  wire dpmbx_pkg::dpmbx_word_t pci_wdata,
  output var  dpmbx_pkg::dpmbx_word_t pci_rdata,
  output var  logic                   pci_ack,
  // pci interrupt line
  output var  logic                   pci_int_n,
  // local side register port
  input  wire logic                   loc_cs,
  input  wire logic                   loc_we,
  input  wire dpmbx_pkg::dpmbx_addr_t loc_addr,
  input  wire dpmbx_pkg::dpmbx_be_t   loc_be,
  input  wire dpmbx_pkg::dpmbx_word_t loc_wdata,
  output var  dpmbx_pkg::dpmbx_word_t loc_rdata,
  output var  logic                   loc_ack,
  // local interrupt pin
  output var  logic                   loc_irq_n
);
  import dpmbx_pkg::*;

  // ****************************************************************
  // storage and state
  // ****************************************************************
  // pci outgoing mailboxes, seen by the local side as incoming
  logic [7:0]    p2l_mb [16];
  // local outgoing mailboxes, seen by the pci side as incoming
  logic [7:0]    l2p_mb [16];
  dpmbx_flags_t  p2l_full;
  dpmbx_flags_t  l2p_full;

  dpmbx_cfg_t    pci_ob_cfg;
  dpmbx_cfg_t    pci_ib_cfg;
  dpmbx_cfg_t    loc_ib_cfg;
  dpmbx_cfg_t    loc_ob_cfg;
  logic          pci_req_ob;
  logic          pci_req_ib;
  logic          loc_req_ib;
  logic          loc_req_ob;

  // ****************************************************************
  // access pulses and read-back words
  // ****************************************************************
  dpmbx_flags_t  pci_out_wr;
  dpmbx_flags_t  pci_in_rd;
  logic          pci_irq_wr;
  logic          pci_gen_wr;
  dpmbx_flags_t  loc_out_wr;
  dpmbx_flags_t  loc_in_rd;
  logic          loc_irq_wr;
  logic          loc_gen_wr;

  logic [127:0]  p2l_words;
  logic [127:0]  l2p_words;
  dpmbx_word_t   flags_word;
  dpmbx_word_t   pci_irq_word;
  dpmbx_word_t   loc_irq_word;

  logic          flag_rst;
  logic          pci_ob_evt;
  logic          pci_ib_evt;
  logic          loc_ib_evt;
  logic          loc_ob_evt;
  logic          pci_clr_ob;
  logic          pci_clr_ib;
  logic          loc_clr_ib;
  logic          loc_clr_ob;

  // ****************************************************************
  // register ports
  // ****************************************************************
  // both ports run on sys_clk, so no synchronisers sit here
  dpmbx_port u_pci_port
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .cs        (pci_cs),
    .we        (pci_we),
    .addr      (pci_addr),
    .be        (pci_be),
    .rdata     (pci_rdata),
    .ack       (pci_ack),
    .out_words (p2l_words),
    .in_words  (l2p_words),
    .flags     (flags_word),
    .irq_word  (pci_irq_word),
    .out_wr    (pci_out_wr),
    .in_rd     (pci_in_rd),
    .irq_wr    (pci_irq_wr),
    .gen_wr    (pci_gen_wr)
  );

  dpmbx_port u_loc_port
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .cs        (loc_cs),
    .we        (loc_we),
    .addr      (loc_addr),
    .be        (loc_be),
    .rdata     (loc_rdata),
    .ack       (loc_ack),
    .out_words (l2p_words),
    .in_words  (p2l_words),
    .flags     (flags_word),
    .irq_word  (loc_irq_word),
    .out_wr    (loc_out_wr),
    .in_rd     (loc_in_rd),
    .irq_wr    (loc_irq_wr),
    .gen_wr    (loc_gen_wr)
  );

  // ****************************************************************
  // flag reset, write-one only, either side
  // ****************************************************************
  // a write setting a flag in the same edge still wins
  assign flag_rst =
    (pci_gen_wr && pci_be[3] && pci_wdata[`DPMBX_BIT_FLAG_RST]) ||
    (loc_gen_wr && loc_be[3] && loc_wdata[`DPMBX_BIT_FLAG_RST]);

  // ****************************************************************
  // mailbox bytes and their flags, one entry per byte
  // ****************************************************************
  generate
    for (genvar i = 0; i < 16; i++)
    begin : g_byte
      // data, a full byte is overwritten without a wait
      // a read of an empty byte returns the old data
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          p2l_mb[i] <= `DPMBX_RST_BYTE;
          l2p_mb[i] <= `DPMBX_RST_BYTE;
        end
        else
        begin
          if (pci_out_wr[i])
            p2l_mb[i] <= pci_wdata[8*(i%4) +: 8];
          if (loc_out_wr[i])
            l2p_mb[i] <= loc_wdata[8*(i%4) +: 8];
        end
      end

      // flags: a write sets, a read or a flag reset clears; set wins
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          p2l_full[i] <= 1'b0;
          l2p_full[i] <= 1'b0;
        end
        else
        begin
          if (pci_out_wr[i])
            p2l_full[i] <= 1'b1;
          else if (loc_in_rd[i] || flag_rst)
            p2l_full[i] <= 1'b0;
          if (loc_out_wr[i])
            l2p_full[i] <= 1'b1;
          else if (pci_in_rd[i] || flag_rst)
            l2p_full[i] <= 1'b0;
        end
      end

      assign p2l_words[8*i +: 8] = p2l_mb[i];
      assign l2p_words[8*i +: 8] = l2p_mb[i];
    end
  endgenerate

  // one flag word serves both sides: upper half local outgoing,
  // lower half pci outgoing
  assign flags_word = {l2p_full, p2l_full};

  // ****************************************************************
  // interrupt configuration, both halves in one write
  // ****************************************************************
  // byte lane 0 carries the low half, lane 1 the high half
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pci_ob_cfg <= `DPMBX_RST_CFG;
      pci_ib_cfg <= `DPMBX_RST_CFG;
    end
    else if (pci_irq_wr)
    begin
      if (pci_be[0])
        pci_ob_cfg <= pci_wdata[`DPMBX_BIT_LOW_EN:0];
      if (pci_be[1])
        pci_ib_cfg <= pci_wdata[`DPMBX_BIT_HIGH_EN:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loc_ib_cfg <= `DPMBX_RST_CFG;
      loc_ob_cfg <= `DPMBX_RST_CFG;
    end
    else if (loc_irq_wr)
    begin
      if (loc_be[0])
        loc_ib_cfg <= loc_wdata[`DPMBX_BIT_LOW_EN:0];
      if (loc_be[1])
        loc_ob_cfg <= loc_wdata[`DPMBX_BIT_HIGH_EN:8];
    end
  end

  // ****************************************************************
  // interrupt events on the selected byte
  // ****************************************************************
  // outgoing events come from the far side's read, whose flag clears
  // in the same edge; any read of the selected byte counts, full or not
  assign pci_ob_evt = pci_ob_cfg[4] &&
                      loc_in_rd[pci_ob_cfg[3:0]];
  assign pci_ib_evt = pci_ib_cfg[4] &&
                      loc_out_wr[pci_ib_cfg[3:0]];
  assign loc_ob_evt = loc_ob_cfg[4] &&
                      pci_in_rd[loc_ob_cfg[3:0]];
  assign loc_ib_evt = loc_ib_cfg[4] &&
                      pci_out_wr[loc_ib_cfg[3:0]];

  // write-one clears of the request bits
  // both request bits live in byte lane 2
  assign pci_clr_ob = pci_irq_wr && pci_be[2] &&
                      pci_wdata[`DPMBX_BIT_REQ_A];
  assign pci_clr_ib = pci_irq_wr && pci_be[2] &&
                      pci_wdata[`DPMBX_BIT_REQ_B];
  assign loc_clr_ib = loc_irq_wr && loc_be[2] &&
                      loc_wdata[`DPMBX_BIT_REQ_A];
  assign loc_clr_ob = loc_irq_wr && loc_be[2] &&
                      loc_wdata[`DPMBX_BIT_REQ_B];

  // ****************************************************************
  // sticky requests, an event beats a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pci_req_ob <= 1'b0;
      pci_req_ib <= 1'b0;
    end
    else
    begin
      if (pci_ob_evt)
        pci_req_ob <= 1'b1;
      else if (pci_clr_ob)
        pci_req_ob <= 1'b0;
      if (pci_ib_evt)
        pci_req_ib <= 1'b1;
      else if (pci_clr_ib)
        pci_req_ib <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loc_req_ib <= 1'b0;
      loc_req_ob <= 1'b0;
    end
    else
    begin
      if (loc_ib_evt)
        loc_req_ib <= 1'b1;
      else if (loc_clr_ib)
        loc_req_ib <= 1'b0;
      if (loc_ob_evt)
        loc_req_ob <= 1'b1;
      else if (loc_clr_ob)
        loc_req_ob <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt outputs, active low, one edge behind the requests
  // ****************************************************************
  // registered so both pins come straight from flip-flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pci_int_n <= 1'b1;
      loc_irq_n <= 1'b1;
    end
    else
    begin
      pci_int_n <= !(pci_req_ob || pci_req_ib);
      loc_irq_n <= !(loc_req_ib || loc_req_ob);
    end
  end

  // ****************************************************************
  // control words as read back
  // ****************************************************************
  // unused bits read as zero
  assign pci_irq_word = {14'h0000, pci_req_ib, pci_req_ob,
                         3'h0, pci_ib_cfg, 3'h0, pci_ob_cfg};
  assign loc_irq_word = {14'h0000, loc_req_ob, loc_req_ib,
                         3'h0, loc_ob_cfg, 3'h0, loc_ib_cfg};

endmodule : dpmbx_top

`default_nettype wire

// ---- bench/dpmbx_monitor.sv ----
// port checker for the dual-port mailbox block
`default_nettype none

module dpmbx_monitor
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  // pci side
  input wire logic                   pci_cs,
  input wire logic                   pci_we,
  input wire dpmbx_pkg::dpmbx_addr_t pci_addr,
  input wire dpmbx_pkg::dpmbx_be_t   pci_be,
  input wire dpmbx_pkg::dpmbx_word_t pci_wdata,
  input wire dpmbx_pkg::dpmbx_word_t pci_rdata,
  input wire logic                   pci_ack,
  input wire logic                   pci_int_n,
  // local side
  input wire logic                   loc_cs,
  input wire logic                   loc_we,
  input wire dpmbx_pkg::dpmbx_addr_t loc_addr,
  input wire dpmbx_pkg::dpmbx_be_t   loc_be,
  input wire dpmbx_pkg::dpmbx_word_t loc_wdata,
  input wire dpmbx_pkg::dpmbx_word_t loc_rdata,
  input wire logic                   loc_ack,
  input wire logic                   loc_irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import dpmbx_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // port relations
  // ************************************************************
  pci_ack_a: assert property (pci_cs |=> pci_ack)
    else $error("pci access not acknowledged");
  loc_ack_a: assert property (!loc_cs |=> !loc_ack)
    else $error("local ack without access");
  pci_rdata_a: assert property ($changed(pci_rdata) |->
    $past(pci_cs && !pci_we))
    else $error("pci read data moved without read");
  pci_zero_a: assert property (
    pci_cs && !pci_we && pci_addr >= 6'h28
    |=> pci_rdata == 32'h00000000)
    else $error("pci write-only or unmapped read not zero");
  loc_zero_a: assert property (
    loc_cs && !loc_we && loc_addr >= 6'h28
    |=> loc_rdata == 32'h00000000)
    else $error("local write-only or unmapped read not zero");
  pci_clear_a: assert property (
    pci_cs && pci_we && pci_addr[5:2] == 4'h9
    && pci_be[2] && pci_wdata[17:16] == 2'b11 && !loc_cs |=> ##1 pci_int_n)
    else $error("pci interrupt held after clear");
  loc_clear_a: assert property (
    loc_cs && loc_we && loc_addr[5:2] == 4'h9
    && loc_be[2] && loc_wdata[17:16] == 2'b11 && !pci_cs |=> ##1 loc_irq_n)
    else $error("local interrupt held after clear");
  pci_src_a: assert property ($fell(pci_int_n) |-> $past(loc_cs, 2))
    else $error("pci interrupt without local access");
  loc_src_a: assert property ($fell(loc_irq_n) |-> $past(pci_cs, 2))
    else $error("local interrupt without pci access");
endmodule : dpmbx_monitor

bind dpmbx_top dpmbx_monitor u_mon
(
  .sys_clk(sys_clk), .rst_n(rst_n), .pci_cs(pci_cs), .pci_we(pci_we),
  .pci_addr(pci_addr), .pci_be(pci_be), .pci_wdata(pci_wdata),
  .pci_rdata(pci_rdata), .pci_ack(pci_ack), .pci_int_n(pci_int_n),
  .loc_cs(loc_cs), .loc_we(loc_we), .loc_addr(loc_addr), .loc_be(loc_be),
  .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .loc_ack(loc_ack),
  .loc_irq_n(loc_irq_n)
);

`default_nettype wire

// ---- bench/dpmbx_local_model.sv ----
// behavioural local processor on the mailbox block's local port
`default_nettype none

module dpmbx_local_model
(
  // clock
  input  wire logic                   sys_clk,
  // local register port
  output var  logic                   loc_cs,
  output var  logic                   loc_we,
  output var  dpmbx_pkg::dpmbx_addr_t loc_addr,
  output var  dpmbx_pkg::dpmbx_be_t   loc_be,
  output var  dpmbx_pkg::dpmbx_word_t loc_wdata,
  input  wire dpmbx_pkg::dpmbx_word_t loc_rdata,
  input  wire logic                   loc_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  import dpmbx_pkg::*;

  initial
  begin
    loc_cs = 1'b0;
    loc_we = 1'b0;
    loc_addr = 6'h00;
    loc_be = 4'h0;
    loc_wdata = 32'h00000000;
  end

  // ************************************************************
  // accesses
  // ************************************************************
  // one access: taken on one edge, answer one edge later
  task automatic acc(input logic w, input dpmbx_addr_t a,
    input dpmbx_be_t b, input dpmbx_word_t d,
    output dpmbx_word_t q, output logic k);
    @(negedge sys_clk);
    loc_cs = 1'b1;
    loc_we = w;
    loc_addr = a;
    loc_be = b;
    loc_wdata = d;
    @(negedge sys_clk);
    q = loc_rdata;
    k = loc_ack;
    loc_cs = 1'b0;
    loc_wdata = ~d;
    @(negedge sys_clk);
  endtask : acc

  // polls until the outgoing mailbox reads empty or 50 reads pass, then writes it
  task automatic send(input int mb, input dpmbx_be_t b,
    input dpmbx_word_t d, output logic k);
    dpmbx_word_t q;
    int n;
    n = 0;
    q = 32'hFFFFFFFF;
    while (q[16 + 4 * mb +: 4] !== 4'h0 && n < 50)
    begin
      acc(1'b0, 6'h20, 4'hF, 32'h00000000, q, k);
      n++;
    end
    acc(1'b1, 6'(4 * mb), b, d, q, k);
  endtask : send

  // reads the request bits before servicing the shared pin
  task automatic src(output logic [1:0] r);
    dpmbx_word_t q;
    logic k;
    acc(1'b0, 6'h24, 4'hF, 32'h00000000, q, k);
    r = q[17:16];
  endtask : src
endmodule : dpmbx_local_model

`default_nettype wire

// ---- bench/tb_dpmbx_top.sv ----
// self-checking bench of the dual-port mailbox block
`default_nettype none

module tb_dpmbx_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dpmbx_pkg::*;

  logic        sys_clk;
  logic        rst_n;
  logic        pci_cs;
  logic        pci_we;
  dpmbx_addr_t pci_addr;
  dpmbx_be_t   pci_be;
  dpmbx_word_t pci_wdata;
  dpmbx_word_t pci_rdata;
  logic        pci_ack;
  logic        pci_int_n;
  logic        loc_cs;
  logic        loc_we;
  dpmbx_addr_t loc_addr;
  dpmbx_be_t   loc_be;
  dpmbx_word_t loc_wdata;
  dpmbx_word_t loc_rdata;
  logic        loc_ack;
  logic        loc_irq_n;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  dpmbx_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .pci_cs(pci_cs),
    .pci_we(pci_we), .pci_addr(pci_addr), .pci_be(pci_be),
    .pci_wdata(pci_wdata), .pci_rdata(pci_rdata), .pci_ack(pci_ack),
    .pci_int_n(pci_int_n), .loc_cs(loc_cs), .loc_we(loc_we),
    .loc_addr(loc_addr), .loc_be(loc_be), .loc_wdata(loc_wdata),
    .loc_rdata(loc_rdata), .loc_ack(loc_ack), .loc_irq_n(loc_irq_n));
  dpmbx_local_model u_loc (.sys_clk(sys_clk), .loc_cs(loc_cs),
    .loc_we(loc_we), .loc_addr(loc_addr), .loc_be(loc_be),
    .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .loc_ack(loc_ack));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input dpmbx_word_t got, input dpmbx_word_t exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic pa(input logic w, input dpmbx_addr_t a,
    input dpmbx_be_t b, input dpmbx_word_t d, output dpmbx_word_t q);
    @(negedge sys_clk);
    pci_cs = 1'b1;
    pci_we = w;
    pci_addr = a;
    pci_be = b;
    pci_wdata = d;
    @(negedge sys_clk);
    q = pci_rdata;
    chk(32'(pci_ack), 32'h00000001);
    pci_cs = 1'b0;
    pci_wdata = ~d;
    @(negedge sys_clk);
  endtask : pa

  task automatic pw(input dpmbx_addr_t a, input dpmbx_be_t b,
    input dpmbx_word_t d);
    dpmbx_word_t q;
    pa(1'b1, a, b, d, q);
  endtask : pw

  task automatic prc(input dpmbx_addr_t a, input dpmbx_word_t e);
    dpmbx_word_t q;
    pa(1'b0, a, 4'hF, 32'h00000000, q);
    chk(q, e);
  endtask : prc

  task automatic lw(input dpmbx_addr_t a, input dpmbx_be_t b,
    input dpmbx_word_t d);
    dpmbx_word_t q;
    logic k;
    u_loc.acc(1'b1, a, b, d, q, k);
    chk(32'(k), 32'h00000001);
  endtask : lw

  task automatic lrc(input dpmbx_addr_t a, input dpmbx_word_t e);
    dpmbx_word_t q;
    logic k;
    u_loc.acc(1'b0, a, 4'hF, 32'h00000000, q, k);
    chk(q, e);
  endtask : lrc

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    prc(6'h20, 32'h00000000);
    prc(6'h24, 32'h00000000);
    chk(32'({pci_int_n, loc_irq_n}), 32'h00000003);
  endtask : t_reset

  task automatic t_p2l();
    pw(6'h04, 4'hF, 32'hA1B2C3D4);
    prc(6'h20, 32'h000000F0);
    lrc(6'h20, 32'h000000F0);
    pw(6'h04, 4'h4, 32'h00550000);
    lrc(6'h14, 32'hA155C3D4);
    lrc(6'h20, 32'h00000000);
  endtask : t_p2l

  task automatic t_l2p();
    logic k;
    u_loc.send(2, 4'hF, 32'h11223344, k);
    prc(6'h20, 32'h0F000000);
    prc(6'h18, 32'h11223344);
    lrc(6'h20, 32'h00000000);
  endtask : t_l2p

  task automatic t_pirq();
    pw(6'h24, 4'h3, 32'h0000121D);
    pw(6'h0C, 4'h2, 32'h00007700);
    lrc(6'h1C, 32'h00007700);
    repeat (2) @(negedge sys_clk);
    chk(32'(pci_int_n), 32'h00000000);
    prc(6'h24, 32'h0001121D);
    prc(6'h20, 32'h00000000);
    lw(6'h00, 4'h4, 32'h00990000);
    prc(6'h24, 32'h0003121D);
    pw(6'h24, 4'h4, 32'h00030000);
    repeat (2) @(negedge sys_clk);
    chk(32'(pci_int_n), 32'h00000001);
    prc(6'h20, 32'h00040000);
    prc(6'h10, 32'h00990000);
    prc(6'h20, 32'h00000000);
    pw(6'h24, 4'h1, 32'h00000000);
    lrc(6'h1C, 32'h00007700);
    prc(6'h24, 32'h00001200);
  endtask : t_pirq

  task automatic t_lirq();
    logic [1:0] r;
    lw(6'h24, 4'h3, 32'h00001718);
    pw(6'h08, 4'h1, 32'h000000AB);
    repeat (2) @(negedge sys_clk);
    chk(32'(loc_irq_n), 32'h00000000);
    lrc(6'h24, 32'h00011718);
    lw(6'h04, 4'h8, 32'hCD000000);
    prc(6'h14, 32'hCD000000);
    u_loc.src(r);
    chk(32'(r), 32'h00000003);
    lw(6'h24, 4'h4, 32'h00030000);
    repeat (2) @(negedge sys_clk);
    chk(32'(loc_irq_n), 32'h00000001);
    lrc(6'h18, 32'h000000AB);
  endtask : t_lirq

  task automatic t_frst();
    for (int i = 0; i < 4; i++)
      pw(6'(4 * i), 4'hF, 32'h5A5A5A5A);
    lw(6'h0C, 4'h1, 32'h00000001);
    pw(6'h20, 4'hF, 32'h00000000);
    lw(6'h20, 4'hF, 32'h00000000);
    prc(6'h20, 32'h1000FFFF);
    lw(6'h28, 4'hF, 32'h00000000);
    prc(6'h20, 32'h1000FFFF);
    lw(6'h28, 4'h8, 32'h08000000);
    prc(6'h20, 32'h00000000);
    prc(6'h28, 32'h00000000);
    lrc(6'h2C, 32'h00000000);
    pw(6'h00, 4'h1, 32'h00000001);
    pw(6'h28, 4'h8, 32'h08000000);
    lrc(6'h20, 32'h00000000);
  endtask : t_frst

  // ************************************************************
  // clock, watchdog and main sequence
  // ************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    pci_cs = 1'b0;
    pci_we = 1'b0;
    pci_addr = 6'h00;
    pci_be = 4'h0;
    pci_wdata = 32'h00000000;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_p2l();
    t_l2p();
    t_pirq();
    t_lirq();
    t_frst();
    stop_test();
  end
endmodule : tb_dpmbx_top

`default_nettype wire
